// *** dlf_top.sv ***
// Loop filter configuration bank with coefficient selection and lock status.
// Assumes synchronous inputs from the loop state machine and lock counter.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module dlf_top (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [dlf_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [31:0]                 reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [31:0]                 reg_rdata,
   input  wire logic                        loop_acquire,
   input  wire logic                        ref_invalid,
   input  wire logic [7:0]                  lock_loss_count,
   output logic                             hold_filter_bypass,
   output logic      [4:0]                  hold_filter_coarse,
   output logic      [2:0]                  hold_filter_fine,
   output logic      [3:0]                  hold_history_sec,
   output logic      [4:0]                  loop_bw_coarse,
   output logic      [2:0]                  loop_bw_fine,
   output logic      [2:0]                  loop_damp_coarse,
   output logic      [2:0]                  loop_damp_fine,
   output logic      [28:0]                 slew_limit,
   output logic                             freeze_update,
   output logic                             enter_holdover,
   output logic                             enter_freerun,
   output logic                             lock_loss_over,
   output logic                             irq
);
   import dlf_pkg::*;

   logic [15:0]      hold_q, bw_q, damp_q;
   logic [31:0]      slew_q;
   logic [3:0]       mode_q;
   logic [IRQ_W-1:0] ist_q, imask_q;
   logic             lol_q, ref_q;

   // Address decode
   wire wr_hold  = reg_wr && (reg_addr == ADDR_HOLD);
   wire wr_bw    = reg_wr && (reg_addr == ADDR_BW);
   wire wr_damp  = reg_wr && (reg_addr == ADDR_DAMP);
   wire wr_slew  = reg_wr && (reg_addr == ADDR_SLEW);
   wire wr_mode  = reg_wr && (reg_addr == ADDR_MODE);
   wire wr_imask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
   wire rd_ist   = reg_rd && (reg_addr == ADDR_IRQ_STAT);

   // Field views of the stored words
   wire [4:0] hc_raw    = hold_q[15:11];
   wire [2:0] hf_raw    = hold_q[10:8];
   wire [3:0] hist_raw  = hold_q[7:4];
   wire [3:0] lol_limit = hold_q[3:0];
   wire       use_acq   = loop_acquire && mode_q[MODE_AUTO_BIT];

   // Holdover coefficient conditioning
   wire [4:0] hc_sat = (hc_raw > HOLD_COARSE_MAX) ? HOLD_COARSE_MAX : hc_raw;
   wire [3:0] hist_sat = (hist_raw > HIST_MAX) ? HIST_MAX : hist_raw;
   wire       hbyp = (hc_raw == 5'h00) || (hf_raw == 3'h0);

   // Coefficient selection between acquire and tracking sets
   wire [4:0] bwc_d = use_acq ? bw_q[15:11] : bw_q[7:3];
   wire [2:0] bwf_d = use_acq ? bw_q[10:8] : bw_q[2:0];
   wire [2:0] dc_d  = use_acq ? damp_q[13:11] : damp_q[5:3];
   wire [2:0] df_d  = use_acq ? damp_q[10:8] : damp_q[2:0];

   // Status terms and events
   wire lol_d = ({4'h0, lol_limit} < lock_loss_count);
   wire [IRQ_W-1:0] ev;
   assign ev[IRQ_LOL_SET]  = lol_d && !lol_q;
   assign ev[IRQ_LOL_CLR]  = !lol_d && lol_q;
   assign ev[IRQ_REF_LOSS] = ref_invalid && !ref_q;

   // Read mux, unmapped reads return zero
   logic [31:0] rdata_d;
   always_comb begin
      case (reg_addr)
         ADDR_HOLD:     rdata_d = {16'h0000, hold_q};
         ADDR_BW:       rdata_d = {16'h0000, bw_q};
         ADDR_DAMP:     rdata_d = {16'h0000, damp_q};
         ADDR_SLEW:     rdata_d = slew_q;
         ADDR_MODE:     rdata_d = {28'h0000000, mode_q};
         ADDR_STAT:     rdata_d = {30'h00000000, ref_q, lol_q};
         ADDR_IRQ_STAT: rdata_d = {29'h00000000, ist_q};
         ADDR_IRQ_MASK: rdata_d = {29'h00000000, imask_q};
         default:       rdata_d = 32'h00000000;
      endcase
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q  <= HOLD_RST;
         bw_q    <= BW_RST;
         damp_q  <= DAMP_RST;
         slew_q  <= SLEW_RST;
         mode_q  <= MODE_RST;
         imask_q <= '0;
      end else begin
         if (wr_hold) hold_q <= reg_wdata[15:0];
         if (wr_bw) bw_q <= reg_wdata[15:0];
         if (wr_damp) damp_q <= reg_wdata[15:0] & DAMP_MASK;
         if (wr_slew) slew_q <= reg_wdata & SLEW_MASK;
         if (wr_mode) mode_q <= reg_wdata[3:0];
         if (wr_imask) imask_q <= reg_wdata[IRQ_W-1:0];
      end
   end

   // Sticky events, a new event wins over the clearing read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ist_q <= '0;
         lol_q <= 1'b0;
         ref_q <= 1'b0;
         irq   <= 1'b0;
      end else begin
         ist_q <= (rd_ist ? '0 : ist_q) | ev;
         lol_q <= lol_d;
         ref_q <= ref_invalid;
         irq   <= |(((rd_ist ? '0 : ist_q) | ev) & imask_q);
      end
   end

   // Registered read data and outputs toward the loop filter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata          <= '0;
         hold_filter_bypass <= 1'b0;
         hold_filter_coarse <= '0;
         hold_filter_fine   <= '0;
         hold_history_sec   <= '0;
         loop_bw_coarse     <= '0;
         loop_bw_fine       <= '0;
         loop_damp_coarse   <= '0;
         loop_damp_fine     <= '0;
         slew_limit         <= '0;
         freeze_update      <= 1'b0;
         enter_holdover     <= 1'b0;
         enter_freerun      <= 1'b0;
         lock_loss_over     <= 1'b0;
      end else begin
         reg_rdata          <= reg_rd ? rdata_d : 32'h00000000;
         hold_filter_bypass <= hbyp;
         hold_filter_coarse <= hc_sat;
         hold_filter_fine   <= hf_raw;
         hold_history_sec   <= hist_sat;
         loop_bw_coarse     <= bwc_d;
         loop_bw_fine       <= bwf_d;
         loop_damp_coarse   <= dc_d;
         loop_damp_fine     <= df_d;
         slew_limit         <= slew_q[28:0];
         freeze_update      <= mode_q[MODE_FREEZE_BIT];
         enter_holdover     <= ref_invalid && !mode_q[MODE_FREERUN_BIT];
         enter_freerun      <= ref_invalid && mode_q[MODE_FREERUN_BIT];
         lock_loss_over     <= lol_d;
      end
   end
endmodule

// *** dlf_pkg.sv ***
// Constants for the loop filter configuration register group.
// Assumes a plain register port, one clock at 100 MHz, active-low reset.
package dlf_pkg;
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  ADDR_HOLD       = 4'h0;
   localparam logic [3:0]  ADDR_BW         = 4'h1;
   localparam logic [3:0]  ADDR_DAMP       = 4'h2;
   localparam logic [3:0]  ADDR_SLEW       = 4'h3;
   localparam logic [3:0]  ADDR_MODE       = 4'h4;
   localparam logic [3:0]  ADDR_STAT       = 4'h5;
   localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h6;
   localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h7;
   localparam logic [15:0] HOLD_RST        = 16'h3800;
   localparam logic [15:0] BW_RST          = 16'h7058;
   localparam logic [15:0] DAMP_RST        = 16'h2901;
   localparam logic [15:0] DAMP_MASK       = 16'h3F3F;
   localparam logic [31:0] SLEW_RST        = 32'h01FFFFFF;
   localparam logic [31:0] SLEW_MASK       = 32'h1FFFFFFF;
   localparam logic [3:0]  MODE_RST        = 4'h1;
   localparam logic [4:0]  HOLD_COARSE_MAX = 5'h14;
   localparam logic [3:0]  HIST_MAX        = 4'hA;
   localparam int          MODE_AUTO_BIT   = 0;
   localparam int          MODE_FREERUN_BIT = 1;
   localparam int          MODE_FREEZE_BIT = 2;
   localparam int          IRQ_W           = 3;
   localparam int          IRQ_LOL_SET     = 0;
   localparam int          IRQ_LOL_CLR     = 1;
   localparam int          IRQ_REF_LOSS    = 2;
   localparam int          SLEW_STEP_EXP   = 35;
   typedef enum logic [1:0] {
      DLF_NORMAL   = 2'b00,
      DLF_ACQUIRE  = 2'b01,
      DLF_HOLDOVER = 2'b10,
      DLF_FREERUN  = 2'b11
   } dlf_state_e;
endpackage

// *** dlf_chk.sv ***
// Checker for the loop filter configuration bank.
// Sees only dlf_top ports; bound to every dlf_top instance.
`timescale 1ns/10ps
module dlf_chk
   import dlf_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   input wire logic              ref_invalid,
   input wire logic [7:0]        lock_loss_count,
   input wire logic              hold_filter_bypass,
   input wire logic [4:0]        hold_filter_coarse,
   input wire logic [2:0]        hold_filter_fine,
   input wire logic [3:0]        hold_history_sec,
   input wire logic [28:0]       slew_limit,
   input wire logic              enter_holdover,
   input wire logic              enter_freerun,
   input wire logic              lock_loss_over
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic live_q;
   // High once outputs have been loaded after reset
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) live_q <= 1'b0;
      else live_q <= 1'b1;
   sequence s_slew_wr;
      reg_wr && reg_addr == ADDR_SLEW;
   endsequence
   a_slew_load: assert property (s_slew_wr |-> ##2 slew_limit == $past(reg_wdata[28:0], 2))
      else $error("slew limit not loaded");
   a_hold_sat: assert property (hold_filter_coarse <= HOLD_COARSE_MAX)
      else $error("holdover coarse above cap");
   a_hold_bypass: assert property (live_q |-> hold_filter_bypass ==
      (hold_filter_coarse == 5'h00 || hold_filter_fine == 3'h0)) else $error("bypass wrong");
   a_hist_cap: assert property (hold_history_sec <= HIST_MAX)
      else $error("history above cap");
   a_lol_low: assert property (live_q && lock_loss_count == 8'h00 |=> !lock_loss_over)
      else $error("over-limit with zero count");
   a_lol_high: assert property (lock_loss_count > 8'h0F |=> lock_loss_over)
      else $error("over-limit missing");
   a_ref_route: assert property (ref_invalid |=> enter_holdover ^ enter_freerun)
      else $error("reference loss not routed");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside read slot");
endmodule
bind dlf_top dlf_chk chk (.*);

// *** tb_top.sv ***
// Self-checking bench for the loop filter configuration bank.
// Drives the register port and loop status inputs of one dlf_top.
`timescale 1ns/10ps
module tb_top;
   import dlf_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
   logic        loop_acquire = 1'b0, ref_invalid = 1'b0, hold_filter_bypass, freeze_update;
   logic        enter_holdover, enter_freerun, lock_loss_over;
   logic [3:0]  reg_addr = 4'h0, hold_history_sec;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [7:0]  lock_loss_count = 8'h00;
   logic [4:0]  hold_filter_coarse, loop_bw_coarse;
   logic [2:0]  hold_filter_fine, loop_bw_fine, loop_damp_coarse, loop_damp_fine;
   logic [28:0] slew_limit;
   logic [15:0] hw [3] = '{16'hFFFF, 16'hA905, 16'h0100};
   logic [12:0] he [3] = '{13'h0A7A, 13'h0A10, 13'h1010};
   logic [31:0] rv [5] = '{HOLD_RST, BW_RST, DAMP_RST, SLEW_RST, MODE_RST};
   int          err_count = 0, compares = 0;
   wire  [13:0] coef = {loop_bw_coarse, loop_bw_fine, loop_damp_coarse, loop_damp_fine};
   wire  [12:0] hold_o = {hold_filter_bypass, hold_filter_coarse,
                          hold_filter_fine, hold_history_sec};
   dlf_top uut (.*);
   // 100 MHz clock
   always #5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      step;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic wrap_up;
      if (err_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #200000;
      err_count++;
      wrap_up;
   end
   // Main sequence: reset values, interrupts, holdover, coefficients, slew
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      step;
      chk(hold_o, 13'h1380);
      chk(coef, 14'h1601);
      for (int i = 0; i < 5; i++) rd(i[3:0], rv[i]);
      wr(4'h8, 32'hFFFFFFFF);
      rd(4'h8, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h4);
      @(posedge clk) ref_invalid <= 1'b1;
      step;
      chk(irq, 1'b1);
      chk({enter_holdover, enter_freerun}, 2'b10);
      wr(ADDR_STAT, 32'hFFFFFFFF);
      rd(ADDR_STAT, 32'h2);
      rd(ADDR_IRQ_STAT, 32'h4);
      step;
      chk(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h0);
      @(posedge clk) ref_invalid <= 1'b0;
      @(posedge clk) ref_invalid <= 1'b1;
      step;
      chk(irq, 1'b0);
      rd(ADDR_IRQ_STAT, 32'h4);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_HOLD, {16'h0000, hw[i]});
         chk(hold_o, he[i]);
         for (int c = 0; c < 2; c++) begin
            @(posedge clk) lock_loss_count <= {4'h0, hw[i][3:0]} + c[7:0];
            step;
            chk(lock_loss_over, c[0]);
         end
      end
      wr(ADDR_BW, 32'h0000A3D6);
      wr(ADDR_DAMP, 32'h0000FFFF);
      rd(ADDR_DAMP, 32'h00003F3F);
      wr(ADDR_DAMP, 32'h00001E2C);
      chk(coef, 14'h35AC);
      @(posedge clk) loop_acquire <= 1'b1;
      step;
      chk(coef, 14'h28DE);
      wr(ADDR_MODE, 32'h6);
      chk(coef, 14'h35AC);
      chk({freeze_update, enter_holdover, enter_freerun}, 3'b101);
      wr(ADDR_SLEW, 32'hFFFFFFFF);
      rd(ADDR_SLEW, 32'h1FFFFFFF);
      chk(slew_limit, 29'h1FFFFFFF);
      wrap_up;
   end
endmodule
